/* design/clock_divider_defs.vh */
/*
  Register map, field positions and reset values for the reference and
  feedback cycle dividers. Assumes inclusion by bare name from design files.
*/
// How it works
// RL1: High nibble sets the high-phase length
// RL2: Low nibble sets the low-phase length
// RL3: Each phase lasts word plus one cycles
// RL4: Word 0x7 gives eight-cycle phase
// RL5: Reset words zero, giving divide-by-two
// RL6: Software programs both words to ratio/2-1
// RL7: Ratio is high plus low; alternates continuously
// RL8: Bypass set routes input straight through
`ifndef CLOCK_DIVIDER_DEFS_VH
`define CLOCK_DIVIDER_DEFS_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_REF_B_CYCLES 8'h11
`define IDX_REF_A_CYCLES 8'h12
`define IDX_FB_CYCLES 8'h13
`define IDX_BYPASS 8'h14
`define ADDR_REF_B_CYCLES 8'h44
`define ADDR_REF_A_CYCLES 8'h48
`define ADDR_FB_CYCLES 8'h4c
`define ADDR_BYPASS 8'h50

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define HIGH_MSB 7
`define HIGH_LSB 4
`define LOW_MSB 3
`define LOW_LSB 0
// Divider indices; each bypass bit sits at BYP_LSB plus its index
`define BYP_FB 2
`define BYP_REF_B 1
`define BYP_REF_A 0
`define BYP_LSB 3
`define BYP_MSB 5
`define CYCLES_RESET 8'h00
`define BYPASS_RESET 3'h0
`define TOGGLE_RESET 3'h0
`define CFG_RESET 9'h000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define NUM_DIV 3

`endif

/* design/cycle_divider.v */
/*
  One duty-cycle divider: counts input clock edges, holds the output high
  for high_word+1 cycles and low for low_word+1 cycles. Assumes the words
  are already synchronised to div_clk.
*/
`timescale 1ns/1ns
`include "clock_divider_defs.vh"
module cycle_divider (
  input wire div_clk, // Input clock to be divided
  input wire aresetn, // Synchronous active-low reset
  input wire [3:0] high_word, // High cycles minus one
  input wire [3:0] low_word, // Low cycles minus one
  output reg div_out // Divided output
);
  reg [3:0] count;

  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  // Count up to the word of the current phase, then flip and restart
  always @(posedge div_clk) begin
    if (!aresetn) begin
      count <= 4'h0;
      div_out <= 1'b1;
    end else if (div_out) begin
      if (count >= high_word) begin // RL1 RL3 RL4
        count <= 4'h0;
        div_out <= 1'b0; // RL7
      end else begin
        count <= count + 4'h1;
      end
    end else begin
      if (count >= low_word) begin // RL2 RL3 RL4
        count <= 4'h0;
        div_out <= 1'b1; // RL7
      end else begin
        count <= count + 4'h1;
      end
    end
  end
endmodule // cycle_divider

/* design/ref_clock_cycle_dividers.v */
/*
  AXI4-Lite register slave plus three cycle dividers (reference A,
  reference B, feedback), each on its own input clock. Assumes the input
  clocks run during reset so every divider sees reset; each written word
  reaches its divider clock by a toggle handshake, never bit by bit, and
  writes to one divider are spaced by a few of its input clock edges.
*/
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "clock_divider_defs.vh"
module ref_clock_cycle_dividers (
  input wire aclk, // Register bus clock, 20 MHz
  input wire aresetn, // Synchronous active-low reset
  input wire [7:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [7:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire reference_input_a, // Reference A clock
  input wire reference_input_b, // Reference B clock
  input wire feedback_input, // Feedback clock
  output wire reference_a_out, // Divided reference A
  output wire reference_b_out, // Divided reference B
  output wire feedback_out // Divided feedback
);
  reg [7:0] ref_b_divider_cycles;
  reg [7:0] ref_a_divider_cycles;
  reg [7:0] feedback_divider_cycles;
  reg [2:0] divider_bypass;
  reg [`NUM_DIV-1:0] cfg_toggle;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  wire do_write;
  wire [`NUM_DIV-1:0] div_clk;
  wire [`NUM_DIV*8-1:0] words;
  wire [`NUM_DIV-1:0] div_out;
  wire [`NUM_DIV-1:0] div_bypass_sync;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Address and data are latched independently so either may come first
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ref_b_divider_cycles <= `CYCLES_RESET; // RL5
      ref_a_divider_cycles <= `CYCLES_RESET; // RL5
      feedback_divider_cycles <= `CYCLES_RESET; // RL5
      divider_bypass <= `BYPASS_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        // Only byte lane 0 carries data; upper lanes are ignored
        if (aw_addr == `ADDR_REF_B_CYCLES) begin
          if (w_strb[0]) ref_b_divider_cycles <= w_data[7:0]; // RL1 RL2
        end else if (aw_addr == `ADDR_REF_A_CYCLES) begin
          if (w_strb[0]) ref_a_divider_cycles <= w_data[7:0]; // RL1 RL2
        end else if (aw_addr == `ADDR_FB_CYCLES) begin
          if (w_strb[0]) feedback_divider_cycles <= w_data[7:0];
        end else if (aw_addr == `ADDR_BYPASS) begin
          if (w_strb[0]) divider_bypass <= w_data[`BYP_MSB:`BYP_LSB]; // RL8
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
    end
  end

  // ----------------------------------------
  // Word handoff toward the divider clocks
  // ----------------------------------------
  // A toggle per divider flips on each write with lane 0 strobed to its word or to the bypass
  // register. The registers stand still while the toggle crosses, so the
  // divider side copies them whole instead of bit by bit.
  // Limitation: two writes to one divider within three edges of its input
  // clock may cancel out; keep such writes further apart.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_toggle <= `TOGGLE_RESET;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == `ADDR_REF_B_CYCLES) begin
        cfg_toggle[`BYP_REF_B] <= !cfg_toggle[`BYP_REF_B];
      end else if (aw_addr == `ADDR_REF_A_CYCLES) begin
        cfg_toggle[`BYP_REF_A] <= !cfg_toggle[`BYP_REF_A];
      end else if (aw_addr == `ADDR_FB_CYCLES) begin
        cfg_toggle[`BYP_FB] <= !cfg_toggle[`BYP_FB];
      end else if (aw_addr == `ADDR_BYPASS) begin
        cfg_toggle <= ~cfg_toggle;
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Read mux; unmapped addresses answer with an error and zero data
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `RESP_OKAY;
    if (s_axi_araddr == `ADDR_REF_B_CYCLES) begin
      next_rdata[7:0] = ref_b_divider_cycles;
    end else if (s_axi_araddr == `ADDR_REF_A_CYCLES) begin
      next_rdata[7:0] = ref_a_divider_cycles;
    end else if (s_axi_araddr == `ADDR_FB_CYCLES) begin
      next_rdata[7:0] = feedback_divider_cycles;
    end else if (s_axi_araddr == `ADDR_BYPASS) begin
      next_rdata[`BYP_MSB:`BYP_LSB] = divider_bypass;
    end else begin
      next_rresp = `RESP_SLVERR;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Dividers, one per input clock
  // ----------------------------------------
  assign div_clk = {feedback_input, reference_input_b, reference_input_a};
  assign words = {feedback_divider_cycles, ref_b_divider_cycles, ref_a_divider_cycles};
  assign reference_a_out = div_out[`BYP_REF_A];
  assign reference_b_out = div_out[`BYP_REF_B];
  assign feedback_out = div_out[`BYP_FB];

  genvar i;
  generate
    for (i = 0; i < `NUM_DIV; i = i + 1) begin : g_div
      reg rst_1;
      reg rst_2;
      reg tog_1;
      reg tog_2;
      reg tog_3;
      reg [8:0] cfg;
      wire divided;
      wire div_run;
      // Reset release passes two flops on this divider clock, so the
      // divider never leaves reset on an edge that races the bus clock.
      always @(posedge div_clk[i]) begin
        rst_1 <= aresetn;
        rst_2 <= rst_1;
      end
      // The toggle passes two flops; the third flop marks its edge. The
      // word has stood for two edges by then, so it is copied whole and
      // a divider never runs on a half-written word.
      always @(posedge div_clk[i]) begin
        if (!rst_2) begin
          tog_1 <= 1'b0;
          tog_2 <= 1'b0;
          tog_3 <= 1'b0;
          cfg <= `CFG_RESET; // RL5
        end else begin
          tog_1 <= cfg_toggle[i];
          tog_2 <= tog_1;
          tog_3 <= tog_2;
          if (tog_2 != tog_3) begin
            cfg <= {divider_bypass[i], words[i*8+7:i*8]};
          end
        end
      end
      assign div_bypass_sync[i] = cfg[8];
      // Bypass holds the divider in reset, standing in for power-down
      assign div_run = rst_2 && !div_bypass_sync[i]; // RL8
      cycle_divider u_div (
        .div_clk(div_clk[i]),
        .aresetn(div_run),
        .high_word(cfg[`HIGH_MSB:`HIGH_LSB]),
        .low_word(cfg[`LOW_MSB:`LOW_LSB]),
        .div_out(divided)
      );
      // Bypass passes the input through as divide-by-one
      assign div_out[i] = div_bypass_sync[i] ? div_clk[i] : divided; // RL8
    end
  endgenerate
endmodule // ref_clock_cycle_dividers

/* verification/ref_clock_source.sv */
/* Free-running source for one divider input.
   Assumes nothing of its load. */
`timescale 1ns/1ns
module ref_clock_source #(parameter int half = 10) (
  output logic clk // Clock
);
  // Runs through reset: dividers reset on their own edges
  initial begin
    clk = 1'b0;
    forever #half clk = ~clk;
  end
endmodule // ref_clock_source

/* verification/divider_bus_monitor.sv */
/* Bus checker for the divider registers.
   Assumes a bind to the top module. */
`timescale 1ns/1ns
module divider_bus_monitor (
  input wire aclk, // Clock
  input wire aresetn, // Reset
  input wire s_axi_awready, // In
  input wire s_axi_wready, // In
  input wire s_axi_bvalid, // In
  input wire s_axi_bready, // In
  input wire [1:0] s_axi_bresp, // In
  input wire s_axi_arvalid, // In
  input wire s_axi_arready, // In
  input wire s_axi_rvalid, // In
  input wire s_axi_rready, // In
  input wire [31:0] s_axi_rdata, // In
  input wire [1:0] s_axi_rresp // In
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until taken
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read answer");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  // One write at a time, so requests wait out the response
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  word_width_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h0) else $error("error data set");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // divider_bus_monitor
bind ref_clock_cycle_dividers divider_bus_monitor mon (.*);

/* verification/tb_top.sv */
/* Bench for the cycle dividers: bus tasks and phase timing.
   Assumes free clock sources at each divider input. */
`timescale 1ns/1ns
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, got;
  logic [3:0] s_axi_wstrb;
  logic [1:0] resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire reference_input_a, reference_input_b, feedback_input;
  wire reference_a_out, reference_b_out, feedback_out;
  int err_count = 0, tests_run = 0, ticks = 0, sel = 0, h, l;
  int hp[3] = '{10, 15, 7};
  wire o = sel == 0 ? reference_a_out : sel == 1 ? reference_b_out : feedback_out;
  ref_clock_source #(.half(10)) src_a (.clk(reference_input_a));
  ref_clock_source #(.half(15)) src_b (.clk(reference_input_b));
  ref_clock_source #(.half(7)) src_f (.clk(feedback_input));
  ref_clock_cycle_dividers uut (.*);
  // Bus clock, 50 ns
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Cuts a hang short
  always @(posedge aclk) begin
    ticks++;
    if (ticks == 20000) begin
      err_count++;
      end_of_test;
    end
  end
  task cmp(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Offers address and data together, releases each when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    got = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // Early periods skipped: new words land three input edges after the write, in any phase
  task meas(input int s);
    time t;
    sel = s;
    repeat (3) @(posedge o);
    t = $time;
    @(negedge o);
    h = ($time - t) / (2 * hp[s]);
    t = $time;
    @(posedge o);
    l = ($time - t) / (2 * hp[s]);
  endtask
  task t_reset;
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'h44 + 4 * i));
      cmp("reset word", 32'h0, got);
    end
    meas(2);
    cmp("fb high", 1, h);
    cmp("fb low", 1, l);
  endtask
  task t_phase;
    wr(8'h48, 32'h73);
    rd(8'h48);
    cmp("ref a word", 32'h73, got);
    meas(0);
    cmp("ref a high", 8, h);
    cmp("ref a low", 4, l);
    wr(8'h44, 32'h33);
    meas(1);
    cmp("ref b ratio", 8, h + l);
    wr(8'h4c, 32'h21);
    rd(8'h4c);
    cmp("fb word", 32'h21, got);
    meas(2);
    cmp("fb high three", 3, h);
    cmp("fb low two", 2, l);
  endtask
  task t_err;
    rd(8'h5c);
    cmp("bad rresp", 2'h2, resp);
    cmp("bad rdata", 32'h0, got);
    wr(8'h5c, 32'hff);
    cmp("bad bresp", 2'h2, resp);
    s_axi_wstrb <= 4'he;
    wr(8'h48, 32'h55);
    s_axi_wstrb <= 4'hf;
    cmp("masked bresp", 2'h0, resp);
    rd(8'h48);
    cmp("masked write", 32'h73, got);
  endtask
  task t_bypass;
    wr(8'h50, 32'h8);
    rd(8'h50);
    cmp("bypass word", 32'h8, got);
    repeat (2) begin
      repeat (6) @(posedge reference_input_a);
      #3 cmp("bypass hi", reference_input_a, reference_a_out);
      @(negedge reference_input_a);
      #3 cmp("bypass lo", reference_input_a, reference_a_out);
    end
  endtask
  task end_of_test;
    $display("Checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Inputs settled at time zero, reset for 16 cycles
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_phase;
    t_err;
    t_bypass;
    end_of_test;
  end
endmodule // tb_top
